// ==== pkg/flag_exec_pkg.sv ====
`default_nettype none
package flag_exec_pkg;
    // flag word bit positions
    localparam int CARRY_POS = 0;
    localparam int PARITY_POS = 2;
    localparam int AUX_POS = 4;
    localparam int ZERO_POS = 6;
    localparam int SIGN_POS = 7;
    localparam int TRAP_POS = 8;
    localparam int IE_POS = 9;
    localparam int DIR_POS = 10;
    localparam int OVF_POS = 11;
    localparam int IO_PRIVILEGE_FIELD_LO = 12;
    localparam int IO_PRIVILEGE_FIELD_HI = 13;
    localparam int NT_POS = 14;
    // flag bits a pop may load; bit 15 and undefined bits keep their value
    localparam logic [15:0] POP_WRITABLE = 16'h7FD5;
    localparam logic [15:0] FLAGS_RESET = 16'h0000;
    localparam logic [15:0] PTR_RESET = 16'h0000;
    localparam logic [15:0] STACK_STEP = 16'h0002;
    localparam logic [15:0] INDEX_STEP = 16'h0001;
    localparam logic [1:0] MOST_PRIV = 2'h0;
    localparam logic [7:0] TEN = 8'h0A;
    // avalon register offsets (byte addresses)
    localparam logic [7:0] OFS_CMD = 8'h00;
    localparam logic [7:0] OFS_FLAGS = 8'h04;
    localparam logic [7:0] OFS_ACCUM = 8'h08;
    localparam logic [7:0] OFS_STACK = 8'h0C;
    localparam logic [7:0] OFS_SRC_INDEX = 8'h10;
    localparam logic [7:0] OFS_DEST_INDEX = 8'h14;
    localparam logic [7:0] OFS_MODE = 8'h18;
    localparam logic [7:0] OFS_STATUS = 8'h1C;
    localparam logic [7:0] OFS_STACK_WORD = 8'h20;
    localparam logic [31:0] UNMAPPED_READ = 32'hDEAD_BEEF;
    // status register bit positions
    localparam int ST_HALT = 0;
    localparam int ST_LOCK = 1;
    localparam int ST_FAULT = 2;
    localparam int ST_PUSHED = 3;
    // operation codes written to the command register
    typedef enum logic [4:0] {
        nop_op                  = 5'h00,
        set_carry_op            = 5'h01,
        clear_carry_op          = 5'h02,
        complement_carry_op     = 5'h03,
        clear_direction_op      = 5'h04,
        set_direction_op        = 5'h05,
        flags_to_high_byte_op   = 5'h06,
        high_byte_to_flags_op   = 5'h07,
        push_flags_op           = 5'h08,
        pop_flags_op            = 5'h09,
        interrupt_return_op     = 5'h0A,
        interrupt_disable_op    = 5'h0B,
        interrupt_enable_op     = 5'h0C,
        halt_op                 = 5'h0D,
        lock_prefix_op          = 5'h0E,
        packed_add_adjust_op    = 5'h0F,
        packed_sub_adjust_op    = 5'h10,
        unpacked_add_adjust_op  = 5'h11,
        unpacked_sub_adjust_op  = 5'h12,
        unpacked_mul_adjust_op  = 5'h13,
        unpacked_div_adjust_op  = 5'h14,
        string_step_op          = 5'h15
    } op_t;
endpackage
`default_nettype wire

// ==== testbench/flag_exec_asserts.sv ====
`default_nettype none
module flag_exec_asserts
    import flag_exec_pkg::*;
(
    input wire logic        sys_clk,
    input wire logic        sys_rst,
    input wire logic [7:0]  address,
    input wire logic        write,
    input wire logic [31:0] writedata,
    input wire logic        read,
    input wire logic        waitrequest,
    input wire logic        maskable_irq,
    input wire logic        nmi_irq,
    input wire logic        irq_accept,
    input wire logic        bus_lock,
    input wire logic        protection_fault,
    input wire logic        halted
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (sys_rst);
    ////////////////////////////////////////////////////////////////////////
    // a command takes effect at the edge where waitrequest is sampled low
    logic       cmd_done;
    logic [4:0] cmd_code;
    assign cmd_done = write && !waitrequest && address == OFS_CMD;
    assign cmd_code = writedata[4:0];
    ////////////////////////////////////////////////////////////////////////
    wait_answer_a: assert property ((read || write) && waitrequest
        |=> !waitrequest) else $error("no answer after one wait state");
    wait_pulse_a: assert property (!waitrequest |=> waitrequest)
        else $error("waitrequest low for two cycles");
    reset_clear_a: assert property ($fell(sys_rst) |->
        waitrequest && !halted && !bus_lock && !protection_fault
        && !irq_accept) else $error("outputs not cleared by reset");
    halt_cause_a: assert property ($rose(halted) |->
        $past(cmd_done && cmd_code == halt_op))
        else $error("halt without halt command");
    halt_wake_a: assert property (halted && nmi_irq |->
        ##[1:3] !halted) else $error("nmi did not end halt");
    nmi_take_a: assert property ($rose(nmi_irq) |->
        ##[1:2] irq_accept) else $error("nmi not accepted");
    accept_cause_a: assert property ($rose(irq_accept) |->
        $past(nmi_irq || maskable_irq)) else $error("accept without irq");
    fault_cause_a: assert property ($rose(protection_fault) |->
        $past(cmd_done)) else $error("fault without command");
    lock_cause_a: assert property ($rose(bus_lock) |->
        $past(cmd_done && cmd_code == lock_prefix_op))
        else $error("lock without lock prefix");
    // the lock may only drop once the following command has run
    lock_hold_a: assert property ($fell(bus_lock) && !$past(sys_rst) |->
        $past(cmd_done) || $past(cmd_done, 2))
        else $error("lock dropped early");
    cover property (cmd_done && cmd_code == pop_flags_op);
    cover property (halted && nmi_irq);
    cover property ($rose(protection_fault));
    cover property ($fell(bus_lock));
endmodule
bind flag_bcd_trusted_exec flag_exec_asserts i_chk (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .address(address),
    .write(write), .writedata(writedata), .read(read),
    .waitrequest(waitrequest), .maskable_irq(maskable_irq),
    .nmi_irq(nmi_irq), .irq_accept(irq_accept), .bus_lock(bus_lock),
    .protection_fault(protection_fault), .halted(halted));
`default_nettype wire

// ==== testbench/tb.sv ====
`default_nettype none
module tb
    import flag_exec_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct {op_t op; logic [15:0] fi, ai, fe, ae, fm;} row_t;
    logic        sys_clk      = 1'b0;
    logic        sys_rst      = 1'b1;
    logic [7:0]  address      = 8'h00;
    logic        read         = 1'b0;
    logic        write        = 1'b0;
    logic [31:0] writedata    = 32'h0;
    logic [3:0]  byteenable   = 4'h3;
    logic        maskable_irq = 1'b0;
    logic        nmi_irq      = 1'b0;
    logic [31:0] readdata, q;
    logic        waitrequest, irq_accept, bus_lock, protection_fault, halted;
    int          fails        = 0;
    int          checks_done  = 0;
    op_t         tops [4]     = '{interrupt_disable_op, interrupt_enable_op,
                                  lock_prefix_op, halt_op};
    // op, flags in, accum in, flags out, accum out, flag mask
    row_t rows [$] = '{
        '{set_carry_op, 16'h0000, 16'h0000, 16'h0001, 16'h0000, 16'hFFFF},
        '{clear_carry_op, 16'h08D5, 16'h0, 16'h08D4, 16'h0, 16'hFFFF},
        '{complement_carry_op, 16'h0001, 16'h0, 16'h0000, 16'h0, 16'hFFFF},
        '{complement_carry_op, 16'h0040, 16'h0, 16'h0041, 16'h0, 16'hFFFF},
        '{set_direction_op, 16'h0001, 16'h0, 16'h0401, 16'h0, 16'hFFFF},
        '{clear_direction_op, 16'h0FD5, 16'h0, 16'h0BD5, 16'h0, 16'hFFFF},
        '{flags_to_high_byte_op, 16'h00D5, 16'h1234, 16'h00D5, 16'hD534,
          16'hFFFF},
        '{flags_to_high_byte_op, 16'h0041, 16'h0, 16'h0041, 16'h4100,
          16'hFFFF},
        '{high_byte_to_flags_op, 16'h0800, 16'hFF12, 16'h08D5, 16'hFF12,
          16'hFFFF},
        '{packed_add_adjust_op, 16'h0, 16'h009A, 16'h0001, 16'h0, 16'h0001},
        '{packed_add_adjust_op, 16'h0, 16'h000F, 16'h0, 16'h0015, 16'h0001},
        '{packed_sub_adjust_op, 16'h0001, 16'h00F0, 16'h0001, 16'h0090,
          16'h0001},
        '{unpacked_add_adjust_op, 16'h0, 16'h010B, 16'h0001, 16'h0201,
          16'h0001},
        '{unpacked_add_adjust_op, 16'h1, 16'h0335, 16'h0, 16'h0305, 16'h1},
        '{unpacked_sub_adjust_op, 16'h0, 16'h02FF, 16'h0001, 16'h0109,
          16'h0001},
        '{unpacked_mul_adjust_op, 16'h0, 16'h773F, 16'h0, 16'h0603, 16'h0},
        '{unpacked_div_adjust_op, 16'h0, 16'h0705, 16'h0, 16'h004B, 16'h0},
        '{unpacked_div_adjust_op, 16'h0, 16'h0909, 16'h0, 16'h0063, 16'h0}};
    flag_bcd_trusted_exec i_dut (
        .sys_clk(sys_clk), .sys_rst(sys_rst), .address(address),
        .read(read), .write(write), .writedata(writedata),
        .byteenable(byteenable), .readdata(readdata),
        .waitrequest(waitrequest), .maskable_irq(maskable_irq),
        .nmi_irq(nmi_irq), .irq_accept(irq_accept), .bus_lock(bus_lock),
        .protection_fault(protection_fault), .halted(halted));
    ////////////////////////////////////////////////////////////////////////
    // 200 MHz clock
    initial begin
        forever #2.5 sys_clk = ~sys_clk;
    end
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        checks_done++;
        if (s !== e) begin
            fails++;
            $display("BAD %0t seen %h expected %h", $time, s, e);
        end
    endtask
    // request held until waitrequest is sampled low; the idle edge after
    // release keeps two requests from landing in one time step
    task automatic av(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
        write     <= w;
        read      <= !w;
        address   <= a;
        writedata <= d;
        @(posedge sys_clk);
        while (waitrequest !== 1'b0) @(posedge sys_clk);
        q = readdata;
        write <= 1'b0;
        read  <= 1'b0;
        @(posedge sys_clk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        av(1'b1, a, 32'(d));
    endtask
    task automatic rdc(input logic [7:0] a, input logic [15:0] e);
        av(1'b0, a, 32'h0);
        chk(q, 32'(e));
    endtask
    task automatic cmd(input op_t o);
        av(1'b1, OFS_CMD, 32'(o));
    endtask
    task tally_and_finish;
        $display("checks %0d mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////
    // watchdog: the whole sequence needs well under 5000 cycles
    initial begin
        repeat (5000) @(posedge sys_clk);
        fails++;
        tally_and_finish;
    end
    initial begin
        repeat (16) @(posedge sys_clk);
        sys_rst <= 1'b0;
        @(posedge sys_clk);
        foreach (rows[i]) begin
            wr(OFS_FLAGS, rows[i].fi);
            wr(OFS_ACCUM, rows[i].ai);
            cmd(rows[i].op);
            av(1'b0, OFS_FLAGS, 32'h0);
            chk(q & 32'(rows[i].fm), 32'(rows[i].fe & rows[i].fm));
            rdc(OFS_ACCUM, rows[i].ae);
        end
        $display("test table done");
        // second reset in mid-run must clear direction and interrupt enable
        wr(OFS_FLAGS, 16'h0600);
        sys_rst <= 1'b1;
        repeat (2) @(posedge sys_clk);
        sys_rst <= 1'b0;
        @(posedge sys_clk);
        rdc(OFS_FLAGS, 16'h0000);
        av(1'b0, 8'h24, 32'h0);
        chk(q, UNMAPPED_READ);
        $display("test reset done");
        wr(OFS_STACK, 16'h0100);
        wr(OFS_FLAGS, 16'h0C55);
        cmd(push_flags_op);
        rdc(OFS_STACK, 16'h00FE);
        rdc(OFS_FLAGS, 16'h0C55);
        av(1'b0, OFS_STACK_WORD, 32'h0);
        chk(q >> 16, 32'h0000_0C55);
        wr(OFS_STACK_WORD, 16'h3201);
        cmd(pop_flags_op);
        rdc(OFS_FLAGS, 16'h3201);
        rdc(OFS_STACK, 16'h0100);
        // protected, level 3: io field kept, interrupt enable follows only while the io field is 3
        wr(OFS_MODE, 16'h0007);
        wr(OFS_STACK_WORD, 16'h0001);
        cmd(pop_flags_op);
        rdc(OFS_FLAGS, 16'h3001);
        wr(OFS_FLAGS, 16'h0200);
        wr(OFS_STACK_WORD, 16'h3000);
        cmd(pop_flags_op);
        rdc(OFS_FLAGS, 16'h0200);
        $display("test stack done");
        foreach (tops[i]) begin
            cmd(tops[i]);
            chk(32'(protection_fault), 32'h1);
            chk(32'(bus_lock | halted), 32'h0);
            rdc(OFS_FLAGS, 16'h0200);
            wr(OFS_STATUS, 16'h0004);
            chk(32'(protection_fault), 32'h0);
        end
        $display("test trusted done");
        // level 0 protected: disable allowed, halt allowed
        wr(OFS_MODE, 16'h0001);
        cmd(interrupt_disable_op);
        chk(32'(protection_fault), 32'h0);
        rdc(OFS_FLAGS, 16'h0000);
        cmd(halt_op);
        chk(32'(halted), 32'h1);
        maskable_irq <= 1'b1;
        repeat (4) @(posedge sys_clk);
        chk(32'(halted | irq_accept), 32'h1);
        nmi_irq <= 1'b1;
        repeat (3) @(posedge sys_clk);
        chk(32'({halted, irq_accept}), 32'h1);
        nmi_irq      <= 1'b0;
        maskable_irq <= 1'b0;
        // real mode ignores the privilege level entirely
        wr(OFS_MODE, 16'h0006);
        cmd(interrupt_enable_op);
        chk(32'(protection_fault), 32'h0);
        rdc(OFS_FLAGS, 16'h0200);
        maskable_irq <= 1'b1;
        repeat (3) @(posedge sys_clk);
        chk(32'(irq_accept), 32'h1);
        maskable_irq <= 1'b0;
        repeat (3) @(posedge sys_clk);
        cmd(halt_op);
        chk(32'(halted), 32'h1);
        maskable_irq <= 1'b1;
        repeat (4) @(posedge sys_clk);
        chk(32'(halted), 32'h0);
        maskable_irq <= 1'b0;
        $display("test interrupt done");
        cmd(lock_prefix_op);
        chk(32'(bus_lock), 32'h1);
        rdc(OFS_FLAGS, 16'h0200);
        cmd(set_carry_op);
        repeat (2) @(posedge sys_clk);
        chk(32'(bus_lock), 32'h0);
        rdc(OFS_FLAGS, 16'h0201);
        wr(OFS_SRC_INDEX, 16'h0000);
        wr(OFS_DEST_INDEX, 16'hFFFF);
        cmd(clear_direction_op);
        cmd(string_step_op);
        rdc(OFS_SRC_INDEX, 16'h0001);
        rdc(OFS_DEST_INDEX, 16'h0000);
        cmd(set_direction_op);
        cmd(string_step_op);
        cmd(string_step_op);
        rdc(OFS_SRC_INDEX, 16'hFFFF);
        rdc(OFS_DEST_INDEX, 16'hFFFE);
        $display("test lock and string done");
        tally_and_finish;
    end
endmodule
`default_nettype wire

// ==== verilog/flag_bcd_trusted_exec.sv ====
// The register offsets and the Avalon-MM interface to the registers are this design's own decisions.
`default_nettype none
module flag_bcd_trusted_exec
    import flag_exec_pkg::*;
(
    input  wire logic        sys_clk,
    input  wire logic        sys_rst,
    input  wire logic [7:0]  address,
    input  wire logic        read,
    input  wire logic        write,
    input  wire logic [31:0] writedata,
    input  wire logic [3:0]  byteenable,
    output logic      [31:0] readdata,
    output logic             waitrequest,
    input  wire logic        maskable_irq,
    input  wire logic        nmi_irq,
    output logic             irq_accept,
    output logic             bus_lock,
    output logic             protection_fault,
    output logic             halted
);

    ////////////////////////////////////////////////////////////////////////
    // architectural state
    logic [15:0] flags;
    logic [15:0] accum;
    logic [15:0] stack_pointer;
    logic [15:0] src_index;
    logic [15:0] dest_index;
    logic [15:0] stack_word;
    logic [15:0] pushed_word;
    logic [1:0]  current_privilege;
    logic        protected_mode;
    logic        lock_pending;
    logic        pushed;
    logic        ack_phase;

    logic carry_flag;
    logic direction_flag;
    logic interrupt_enable_flag;
    logic [1:0] io_privilege_field;
    logic [7:0] accum_high_byte;
    logic [7:0] accum_low_byte;
    assign carry_flag = flags[CARRY_POS];
    assign direction_flag = flags[DIR_POS];
    assign interrupt_enable_flag = flags[IE_POS];
    assign io_privilege_field = flags[IO_PRIVILEGE_FIELD_HI:IO_PRIVILEGE_FIELD_LO];
    assign accum_high_byte = accum[15:8];
    assign accum_low_byte = accum[7:0];

    ////////////////////////////////////////////////////////////////////////
    // bus decode; one wait state so every access answers on the second edge
    wire sel_cmd   = address == OFS_CMD;
    wire sel_flags = address == OFS_FLAGS;
    wire sel_accum = address == OFS_ACCUM;
    wire sel_stack = address == OFS_STACK;
    wire sel_src   = address == OFS_SRC_INDEX;
    wire sel_dst   = address == OFS_DEST_INDEX;
    wire sel_mode  = address == OFS_MODE;
    wire sel_stat  = address == OFS_STATUS;
    wire sel_sword = address == OFS_STACK_WORD;
    wire wr_go     = write && ack_phase;
    wire rd_go     = read && ack_phase;
    wire low_en    = byteenable[0] || byteenable[1];
    wire op_valid  = wr_go && sel_cmd && byteenable[0];
    wire [4:0] op_raw = writedata[4:0];
    op_t op;
    assign op = op_t'(op_raw);

    // merge byte lanes 0 and 1 into a 16-bit register
    function automatic logic [15:0] lane_merge(input logic [15:0] old,
                                               input logic [31:0] d,
                                               input logic [3:0] be);
        lane_merge = {be[1] ? d[15:8] : old[15:8],
                      be[0] ? d[7:0] : old[7:0]};
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // privilege tests, real mode passes everything
    wire io_trusted   = !protected_mode ||
                        (current_privilege <= io_privilege_field);
    wire level0       = !protected_mode ||
                        (current_privilege == MOST_PRIV);
    wire is_int_op    = op == interrupt_disable_op ||
                        op == interrupt_enable_op;
    wire trust_fault  = op_valid && !io_trusted &&
                        (is_int_op || op == lock_prefix_op);
    wire halt_fault   = op_valid && op == halt_op && !level0;
    wire any_fault    = trust_fault || halt_fault;
    // halt ends on an accepted interrupt; nmi always, maskable by bit 9
    wire wake         = nmi_irq || (maskable_irq && interrupt_enable_flag);

    ////////////////////////////////////////////////////////////////////////
    // decimal adjust arithmetic
    wire       aux_in   = flags[AUX_POS];
    wire       lo_big   = accum_low_byte[3:0] > 4'h9;
    wire       adj_lo   = lo_big || aux_in;
    wire       hi_big   = accum_low_byte > 8'h99;
    wire       adj_hi   = hi_big || carry_flag;
    wire [7:0] pk_step  = {adj_hi ? 4'h6 : 4'h0, adj_lo ? 4'h6 : 4'h0};
    wire [7:0] daa_res  = accum_low_byte + pk_step;
    wire [7:0] das_res  = accum_low_byte - pk_step;
    wire [7:0] ua_low   = accum_low_byte + 8'h06;
    wire [7:0] us_low   = accum_low_byte - 8'h06;
    wire [7:0] mul_hi   = accum_low_byte / TEN;
    wire [7:0] mul_lo   = accum_low_byte % TEN;
    wire [15:0] div_wide = accum_high_byte * TEN;
    wire [7:0] div_res  = div_wide[7:0] + accum_low_byte;

    // flag bits a pop is allowed to change
    logic [15:0] pop_mask;
    assign pop_mask = POP_WRITABLE
        & ~(level0 ? 16'h0000 : 16'h3000)
        & ~(io_trusted ? 16'h0000 : 16'h0200);

    ////////////////////////////////////////////////////////////////////////
    // next flag and accumulator values for the command just written
    logic [15:0] next_flags;
    logic [15:0] next_accum;
    always_comb begin
        next_flags = flags;
        next_accum = accum;
        if (op_valid && !any_fault) begin
            unique case (op)
                set_carry_op:        next_flags[CARRY_POS] = 1'b1;
                clear_carry_op:      next_flags[CARRY_POS] = 1'b0;
                complement_carry_op: next_flags[CARRY_POS] = !carry_flag;
                clear_direction_op:  next_flags[DIR_POS] = 1'b0;
                set_direction_op:    next_flags[DIR_POS] = 1'b1;
                flags_to_high_byte_op: begin
                    // undefined bits 5, 3 and 1 are returned as zero
                    next_accum[15:8] = {flags[SIGN_POS], flags[ZERO_POS],
                        1'b0, flags[AUX_POS], 1'b0, flags[PARITY_POS],
                        1'b0, flags[CARRY_POS]};
                end
                high_byte_to_flags_op: begin
                    next_flags[SIGN_POS]   = accum[15];
                    next_flags[ZERO_POS]   = accum[14];
                    next_flags[AUX_POS]    = accum[12];
                    next_flags[PARITY_POS] = accum[10];
                    next_flags[CARRY_POS]  = accum[8];
                end
                pop_flags_op, interrupt_return_op: begin
                    next_flags = (flags & ~pop_mask)
                               | (stack_word & pop_mask);
                end
                interrupt_disable_op: next_flags[IE_POS] = 1'b0;
                interrupt_enable_op:  next_flags[IE_POS] = 1'b1;
                packed_add_adjust_op: begin
                    next_accum[7:0] = daa_res;
                    next_flags[CARRY_POS] = adj_hi;
                    next_flags[AUX_POS] = adj_lo;
                end
                packed_sub_adjust_op: begin
                    next_accum[7:0] = das_res;
                    next_flags[CARRY_POS] = adj_hi;
                    next_flags[AUX_POS] = adj_lo;
                end
                unpacked_add_adjust_op: begin
                    next_accum[7:0] = {4'h0, (adj_lo ? ua_low[3:0]
                        : accum_low_byte[3:0])};
                    next_accum[15:8] = accum_high_byte
                        + (adj_lo ? 8'h01 : 8'h00);
                    next_flags[CARRY_POS] = adj_lo;
                    next_flags[AUX_POS] = adj_lo;
                end
                unpacked_sub_adjust_op: begin
                    next_accum[7:0] = {4'h0, (adj_lo ? us_low[3:0]
                        : accum_low_byte[3:0])};
                    next_accum[15:8] = accum_high_byte
                        - (adj_lo ? 8'h01 : 8'h00);
                    next_flags[CARRY_POS] = adj_lo;
                    next_flags[AUX_POS] = adj_lo;
                end
                unpacked_mul_adjust_op: begin
                    next_accum = {mul_hi, mul_lo};
                end
                unpacked_div_adjust_op: begin
                    next_accum = {8'h00, div_res};
                end
                default: begin
                end
            endcase
        end else if (wr_go && sel_flags) begin
            next_flags = lane_merge(flags, writedata, byteenable);
        end else if (wr_go && sel_accum) begin
            next_accum = lane_merge(accum, writedata, byteenable);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // flags, accumulator and mode; reset clears every flag bit
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            flags <= FLAGS_RESET;
            accum <= PTR_RESET;
            protected_mode <= 1'b0;
            current_privilege <= MOST_PRIV;
        end else begin
            flags <= next_flags;
            accum <= next_accum;
            if (wr_go && sel_mode && byteenable[0]) begin
                protected_mode <= writedata[0];
                current_privilege <= writedata[2:1];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // stack pointer, stack word and string index pointers
    wire str_step = op_valid && op == string_step_op;
    wire [15:0] idx_next_src = direction_flag ? src_index - INDEX_STEP
                                              : src_index + INDEX_STEP;
    wire [15:0] idx_next_dst = direction_flag ? dest_index - INDEX_STEP
                                              : dest_index + INDEX_STEP;
    wire is_pop = op == pop_flags_op || op == interrupt_return_op;
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            stack_pointer <= PTR_RESET;
            src_index <= PTR_RESET;
            dest_index <= PTR_RESET;
            stack_word <= PTR_RESET;
            pushed_word <= PTR_RESET;
            pushed <= 1'b0;
        end else if (op_valid && op == push_flags_op) begin
            // word lands at the lowered pointer, flags untouched
            stack_pointer <= stack_pointer - STACK_STEP;
            pushed_word <= flags;
            pushed <= 1'b1;
        end else if (op_valid && is_pop) begin
            stack_pointer <= stack_pointer + STACK_STEP;
            pushed <= 1'b0;
        end else if (str_step) begin
            src_index <= idx_next_src;
            dest_index <= idx_next_dst;
        end else if (wr_go && low_en) begin
            if (sel_stack)
                stack_pointer <= lane_merge(stack_pointer, writedata,
                                            byteenable);
            if (sel_src)
                src_index <= lane_merge(src_index, writedata, byteenable);
            if (sel_dst)
                dest_index <= lane_merge(dest_index, writedata, byteenable);
            if (sel_sword)
                stack_word <= lane_merge(stack_word, writedata, byteenable);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // halt, lock and fault outputs
    // lock covers exactly the one command that follows the prefix
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            halted <= 1'b0;
            lock_pending <= 1'b0;
            bus_lock <= 1'b0;
            protection_fault <= 1'b0;
            irq_accept <= 1'b0;
        end else begin
            // nmi is always taken; maskable only with bit 9 set
            irq_accept <= wake;
            if (halted && wake)
                halted <= 1'b0;
            else if (op_valid && op == halt_op && level0)
                halted <= 1'b1;
            if (any_fault)
                protection_fault <= 1'b1;
            else if (wr_go && sel_stat && writedata[ST_FAULT])
                protection_fault <= 1'b0;
            if (op_valid && op == lock_prefix_op && !trust_fault) begin
                lock_pending <= 1'b1;
                bus_lock <= 1'b1;
            end else if (op_valid && lock_pending) begin
                lock_pending <= 1'b0;
                bus_lock <= 1'b1;
            end else begin
                bus_lock <= lock_pending;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // read mux and handshake
    logic [31:0] next_readdata;
    always_comb begin
        next_readdata = UNMAPPED_READ;
        if (sel_cmd)   next_readdata = 32'h0000_0000;
        if (sel_flags) next_readdata = {16'h0000, flags};
        if (sel_accum) next_readdata = {16'h0000, accum};
        if (sel_stack) next_readdata = {16'h0000, stack_pointer};
        if (sel_src)   next_readdata = {16'h0000, src_index};
        if (sel_dst)   next_readdata = {16'h0000, dest_index};
        if (sel_mode)  next_readdata = {29'h0, current_privilege,
                                        protected_mode};
        if (sel_stat)  next_readdata = {28'h0, pushed, protection_fault,
                                        bus_lock, halted};
        if (sel_sword) next_readdata = {pushed_word, stack_word};
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            ack_phase <= 1'b0;
            waitrequest <= 1'b1;
            readdata <= 32'h0000_0000;
        end else begin
            ack_phase <= (read || write) && !ack_phase;
            // registered copy of the inverse keeps the output glitch free
            waitrequest <= !((read || write) && !ack_phase);
            if ((read || write) && !ack_phase)
                readdata <= next_readdata;
        end
    end
    wire unused_ok = rd_go;

endmodule
`default_nettype wire
